// ---- logic/asp_fifo.sv ----
// Word FIFO between the converter and the output data register
`timescale 1ns/10ps
module asp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} asp_fifo_type;
	asp_fifo_type q;
	asp_fifo_type next_q;
	logic push;
	logic pull;

	// Full and empty straight from the occupancy count
	assign in_ready = (q.count != (AW+1)'(DEPTH));
	assign out_valid = (q.count != '0);
	assign out_data = q.mem[q.rd];
	assign push = in_valid & in_ready;
	assign pull = out_valid & out_ready;

	// Pointer wrap written out so any depth works
	always_comb begin
		next_q = q;
		if (push) begin
			next_q.mem[q.wr] = in_data;
			next_q.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
		end
		if (pull) begin
			next_q.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
		end
		next_q.count = q.count + (AW+1)'(push) - (AW+1)'(pull);
	end

	// Storage keeps its contents over reset; only pointers and count clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			q.wr <= '0;
			q.rd <= '0;
			q.count <= '0;
		end else begin
			q <= next_q;
		end
	end
endmodule // asp_fifo

// ---- logic/asp_pkg.sv ----
// Constants and types shared by the serial port block and its testbench
package asp_pkg;
	// ********************************
	// Register select codes
	// ********************************
	localparam logic [1:0] RS_COMM = 2'h0;
	localparam logic [1:0] RS_SETUP = 2'h1;
	localparam logic [1:0] RS_TEST = 2'h2;
	localparam logic [1:0] RS_DATA = 2'h3;
	// Communications byte field positions
	localparam int COMM_WEN_BIT = 7;
	localparam int COMM_RS_HI = 5;
	localparam int COMM_RS_LO = 4;
	localparam int COMM_RW_BIT = 3;
	localparam int COMM_STBY_BIT = 2;
	// ********************************
	// Widths and reset values
	// ********************************
	localparam int WORD_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam logic [7:0] COMM_RST = 8'h00;
	localparam logic [7:0] SETUP_RST = 8'h00;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [4:0] BYTE_LAST = 5'h07;
	localparam logic [4:0] WORD_LAST = 5'h0f;
	// ********************************
	// Timing
	// ********************************
	localparam int CLK_NS = 100;
	localparam int MCLK_NS = 100;
	localparam int HOLD_MCLK = 500;
	localparam int HOLD_NS = HOLD_MCLK * MCLK_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [8:0] HOLD_LAST = 9'(HOLD_CYC - 1);
	localparam int ONES_LIMIT = 32;
	localparam logic [4:0] ONES_LAST = 5'(ONES_LIMIT - 1);
	// ********************************
	// State types
	// ********************************
	typedef enum logic [1:0] {
		M_COMM = 2'b00,
		M_WR = 2'b01,
		M_RD = 2'b10
	} asp_mode_type;
	typedef enum logic [0:0] {
		U_IDLE = 1'b0,
		U_HOLD = 1'b1
	} asp_upd_type;
endpackage

// ---- logic/asp_port.sv ----
// Serial port, data-ready flag and master clock output of the converter
`timescale 1ns/10ps
// Function
// - Data-ready goes low once a new word sits in the data register.
// - Data-ready goes high after a complete data word has been read.
// - Unread data: data-ready high 500 master clocks before the next update.
// - Data-ready returns low when the data register update is done.
// - Data-ready also goes low when calibration finishes while no data register update runs or starts.
// - Chip select is active low; the port answers only while selected.
// - Chip select tied low gives a three-wire port.
// - Reset low returns all logic except the FIFO storage to its power-on state.
// - Output shifter loads from comm, setup or data register by select.
// - Input shifter moves into setup or comm register by select.
// - Master clock output is the inverted master clock input.
// - After the selected access the port awaits a comm write again.
// - 32 serial clocks with data in high reset the port sequence outside a read.
// - Select value zero addresses the comm register.
module asp_port (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	output logic data_ready_n,
	input wire logic mclk_in,
	output logic mclk_out,
	input wire logic conv_valid,
	output logic conv_ready,
	input wire logic [asp_pkg::WORD_W-1:0] conv_data,
	input wire logic cal_done,
	output logic [7:0] setup_value,
	output logic [1:0] gain,
	output logic standby
);
	import asp_pkg::*;

	typedef struct packed {
		logic sclk_a;
		logic sclk_b;
		logic sclk_c;
		logic cs_a;
		logic cs_b;
		logic din_a;
		logic din_b;
		logic mclk_a;
		logic mclk_b;
		logic mclk_out;
		asp_mode_type mode;
		logic [4:0] cnt;
		logic [4:0] ones;
		logic [7:0] sh_in;
		logic [15:0] sh_out;
		logic [7:0] comm;
		logic [7:0] setup;
		logic [15:0] data;
		logic data_ready_n_n;
		asp_upd_type upd;
		logic [8:0] hold;
	} asp_state_type;

	asp_state_type q;
	asp_state_type next_q;
	logic rise;
	logic fall;
	logic [7:0] wr_byte;
	logic [1:0] sel;
	logic [4:0] rd_last;
	logic pop;
	logic rd_done;
	logic fifo_valid;
	logic [WORD_W-1:0] fifo_data;

	// ********************************
	// Word buffer from the converter
	// ********************************
	asp_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.in_valid(conv_valid),
		.in_ready(conv_ready),
		.in_data(conv_data),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_data)
	);

	// Register image shifted out for a given select code
	function automatic logic [15:0] sel_word(
		input logic [1:0] s,
		input logic [7:0] comm,
		input logic [7:0] setup,
		input logic [15:0] data,
		input logic data_ready_n_n
	);
		case (s)
			RS_COMM: sel_word = {data_ready_n_n, comm[6:0], 8'h00};
			RS_SETUP: sel_word = {setup, 8'h00};
			RS_DATA: sel_word = data;
			default: sel_word = 16'h0000;
		endcase
	endfunction

	// Edges only count while selected; deselect freezes the position
	assign rise = q.sclk_b & ~q.sclk_c & ~q.cs_b;
	assign fall = ~q.sclk_b & q.sclk_c & ~q.cs_b;
	assign wr_byte = {q.sh_in[6:0], q.din_b};
	assign sel = q.comm[COMM_RS_HI:COMM_RS_LO];
	assign rd_last = (sel == RS_DATA) ? WORD_LAST : BYTE_LAST;

	// ********************************
	// Next-state logic
	// ********************************
	always_comb begin
		next_q = q;
		pop = 1'b0;
		rd_done = 1'b0;
		// Pins cross in two flops; the first is read by nothing else
		next_q.sclk_a = sclk;
		next_q.sclk_b = q.sclk_a;
		next_q.sclk_c = q.sclk_b;
		next_q.cs_a = cs_n;
		next_q.cs_b = q.cs_a;
		next_q.din_a = din;
		next_q.din_b = q.din_a;
		next_q.mclk_a = mclk_in;
		next_q.mclk_b = q.mclk_a;
		next_q.mclk_out = ~q.mclk_b;
		// Port samples the data input on rising serial clock edges
		if (rise) begin
			next_q.sh_in = wr_byte;
			next_q.cnt = q.cnt + 5'h01;
			next_q.ones = (q.din_b && q.mode != M_RD) ?
				q.ones + 5'h01 : 5'h00;
			case (q.mode)
				M_COMM: begin
					if (q.cnt == BYTE_LAST) begin
						next_q.cnt = 5'h00;
						// A set top bit is not a valid comm write
						if (!wr_byte[COMM_WEN_BIT]) begin
							next_q.comm = wr_byte;
							if (wr_byte[COMM_RW_BIT]) begin
								next_q.mode = M_RD;
								next_q.sh_out = sel_word(
									wr_byte[COMM_RS_HI:COMM_RS_LO],
									wr_byte, q.setup, q.data, q.data_ready_n_n);
							end else if (wr_byte[COMM_RS_HI:COMM_RS_LO]
								!= RS_COMM) begin
								next_q.mode = M_WR;
							end
						end
					end
				end
				M_WR: begin
					if (q.cnt == BYTE_LAST) begin
						next_q.cnt = 5'h00;
						next_q.mode = M_COMM;
						if (sel == RS_SETUP) begin
							next_q.setup = wr_byte;
						end
					end
				end
				M_RD: begin
					if (q.cnt == rd_last) begin
						next_q.cnt = 5'h00;
						next_q.mode = M_COMM;
						rd_done = (sel == RS_DATA);
					end
				end
				default: begin
					next_q.mode = M_COMM;
				end
			endcase
			// Long run of ones parks the port at the start while it lasts
			if (q.din_b && q.mode != M_RD && q.ones == ONES_LAST) begin
				next_q.mode = M_COMM;
				next_q.cnt = 5'h00;
				next_q.ones = ONES_LAST;
			end
		end
		// Output moves on falling edges, but not the one after loading
		if (fall && q.mode == M_RD && q.cnt != 5'h00) begin
			next_q.sh_out = {q.sh_out[14:0], 1'b0};
		end
		// A finished data read raises the flag
		if (rd_done) begin
			next_q.data_ready_n_n = 1'b1;
		end
		// Data register update; an idle start waits out a read, the load at the end of a hold does not
		case (q.upd)
			U_IDLE: begin
				if (fifo_valid && q.mode != M_RD) begin
					if (!q.data_ready_n_n) begin
						next_q.upd = U_HOLD;
						next_q.hold = HOLD_LAST;
						next_q.data_ready_n_n = 1'b1;
					end else begin
						pop = 1'b1;
					end
				end else if (cal_done) begin
					next_q.data_ready_n_n = 1'b0;
				end
			end
			U_HOLD: begin
				if (q.hold == 9'h000) begin
					pop = 1'b1;
					next_q.upd = U_IDLE;
				end else begin
					next_q.hold = q.hold - 9'h001;
				end
			end
			default: begin
				next_q.upd = U_IDLE;
			end
		endcase
		// Loading wins over a read-done clear in the same cycle
		if (pop) begin
			next_q.data = fifo_data;
			next_q.data_ready_n_n = 1'b0;
		end
	end

	// ********************************
	// State register
	// ********************************
	// Reset brings every part back to power-on values
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			q <= '0;
			q.mode <= M_COMM;
			q.upd <= U_IDLE;
			q.comm <= COMM_RST;
			q.setup <= SETUP_RST;
			q.data <= DATA_RST;
			q.data_ready_n_n <= 1'b1;
			q.cs_a <= 1'b1;
			q.cs_b <= 1'b1;
			q.sclk_a <= 1'b1; // Idle high, so no false edge follows reset
			q.sclk_b <= 1'b1;
			q.sclk_c <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	// Outputs straight from flops; pin released while deselected
	assign dout = q.sh_out[15];
	assign dout_oe = ~q.cs_b;
	assign data_ready_n = q.data_ready_n_n;
	assign mclk_out = q.mclk_out;
	assign setup_value = q.setup;
	assign gain = q.comm[1:0];
	assign standby = q.comm[COMM_STBY_BIT];

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	load_flag_a: assert property (pop |=> !data_ready_n && q.data == $past(fifo_data))
		else $error("data load did not lower data-ready");
	read_done_a: assert property (rd_done && !pop |=> data_ready_n)
		else $error("data read did not raise data-ready");
	hold_len_a: assert property ($rose(q.upd == U_HOLD) |-> ##[499:499] pop)
		else $error("update hold not 500 cycles");
	hold_high_a: assert property (q.upd == U_HOLD |-> data_ready_n)
		else $error("data-ready low during hold");
	cal_flag_a: assert property (cal_done && q.upd == U_IDLE && !fifo_valid
		|=> !data_ready_n)
		else $error("calibration end not flagged");
	deselect_hold_a: assert property (q.cs_b |=> $stable(q.cnt) && $stable(q.mode))
		else $error("port moved while deselected");
	ones_reset_a: assert property (rise && q.din_b && q.mode != M_RD
		&& q.ones == ONES_LAST |=> q.mode == M_COMM && q.cnt == 5'h00)
		else $error("ones run did not reset port");
	read_end_a: assert property (rise && q.mode == M_RD && q.cnt == rd_last
		|=> q.mode == M_COMM)
		else $error("port did not return after read");
	setup_write_a: assert property (rise && q.mode == M_WR && q.cnt == BYTE_LAST
		&& sel == RS_SETUP |=> q.setup == $past(wr_byte))
		else $error("setup write lost");
	data_load_a: assert property ($rose(q.mode == M_RD) && sel == RS_DATA
		|-> q.sh_out == $past(q.data))
		else $error("output shifter not loaded from data");

	hold_seen_c: cover property ($rose(q.upd == U_HOLD));
	data_read_c: cover property (rd_done);
	ones_seen_c: cover property (rise && q.din_b && q.ones == ONES_LAST);
	cal_seen_c: cover property (cal_done && q.upd == U_IDLE);
endmodule // asp_port

// ---- verification/asp_host.sv ----
// Host serial master model for the converter's serial port
`timescale 1ns/10ps
module asp_host (
	input wire logic core_clk,
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout
);
	// ********************************
	// Pin drive
	// ********************************
	// Deselected, serial clock parked high between frames
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// Wait n core clocks, then step just past the edge
	task automatic half(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Released data line wanders so a stale bit is never trusted
	task automatic sel(input logic on);
		cs_n = !on;
		if (!on) din = ~din;
		half(8);
	endtask
	// MSB first: din set on the fall, dout taken mid high phase
	task automatic shift(input logic [31:0] w, input int n,
		output logic [15:0] r);
		r = 16'h0;
		for (int i = n - 1; i >= 0; i--) begin
			sclk = 1'b0;
			din = w[i];
			half(4);
			sclk = 1'b1;
			half(2);
			r = {r[14:0], dout};
			half(2);
		end
	endtask
	// Every access opens with a comm byte
	task automatic access(input logic [7:0] c, input logic [15:0] w,
		input int n, output logic [15:0] r);
		shift({24'h0, c}, 8, r);
		if (n > 0) shift({16'h0, w}, n, r);
	endtask
	// Clock pulses while deselected; the port must not count them
	task automatic noise(input int n);
		for (int i = 0; i < n; i++) begin
			sclk = 1'b0;
			din = 1'($urandom);
			half(4);
			sclk = 1'b1;
			half(4);
		end
	endtask
endmodule // asp_host

// ---- verification/testbench.sv ----
// Self-checking bench for the serial port and data-ready flag
`timescale 1ns/10ps
module testbench;
	import asp_pkg::*;
	logic core_clk, rst_n, mclk_in, conv_valid, cal_done, ok;
	logic sclk, cs_n, din, dout, dout_oe, data_ready_n, mclk_out;
	logic conv_ready, standby;
	logic [15:0] conv_data, r, w;
	logic [7:0] setup_value, setup_m;
	logic [1:0] gain;
	logic [15:0] q[$];
	int fail_count, tests_run, cyc, run, last_high, acc;
	asp_port i_dut (.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk),
		.cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
		.data_ready_n(data_ready_n), .mclk_in(mclk_in),
		.mclk_out(mclk_out), .conv_valid(conv_valid),
		.conv_ready(conv_ready), .conv_data(conv_data),
		.cal_done(cal_done), .setup_value(setup_value), .gain(gain),
		.standby(standby));
	asp_host i_host (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n),
		.din(din), .dout(dout));
	// ********************************
	// Clock, watchdog and flag timing
	// ********************************
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// Length of the latest or ongoing high run; a low may last one cycle
	always @(posedge core_clk) begin
		cyc++;
		if (data_ready_n === 1'b1) begin
			run++;
			last_high = run;
		end else begin
			run = 0;
		end
		if (cyc > 20000) begin
			fail_count++;
			test_done();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bounded wait for a fresh word; a stuck flag counts as a mismatch
	task automatic wait_ready();
		int n;
		n = 0;
		while (data_ready_n !== 1'b0 && n < 2000) begin
			tick(1);
			n++;
		end
		cmp_bit(data_ready_n, 1'b0);
	endtask
	// Model word order: oldest surviving word first
	task automatic read_data();
		wait_ready();
		i_host.access(8'h38, 16'h0, 16, r);
		cmp_word(r, q.pop_front());
		if (q.size() == 0) cmp_bit(data_ready_n, 1'b1);
	endtask
	// Held valid between back-to-back words, cleared by the caller
	task automatic push(input logic [15:0] d, output logic took);
		conv_data = d;
		conv_valid = 1'b1;
		took = conv_ready;
		tick(1);
	endtask
	task automatic test_done();
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ********************************
	// Main sequence
	// ********************************
	initial begin
		rst_n = 1'b0;
		mclk_in = 1'b0;
		conv_valid = 1'b0;
		conv_data = 16'h0;
		cal_done = 1'b0;
		{cyc, run, last_high, fail_count, tests_run} = '0;
		void'($urandom(32'h2aaa));
		tick(8);
		cmp_bit(data_ready_n, 1'b1);
		cmp_bit(dout_oe, 1'b0);
		cmp_word({8'h0, setup_value}, {8'h0, SETUP_RST});
		rst_n = 1'b1;
		tick(4);
		// Output clock follows the input inverted, after the sync lag
		for (int i = 0; i < 4; i++) begin
			mclk_in = i[0];
			tick(5);
			cmp_bit(mclk_out, !i[0]);
		end
		// Chip select held low: three-wire operation from here
		i_host.sel(1'b1);
		cmp_bit(dout_oe, 1'b1);
		for (int g = 0; g < 8; g++) begin
			i_host.access(8'(g), 16'h0, 0, r);
			tick(4);
			cmp_word({13'h0, standby, gain}, 16'(g));
		end
		for (int k = 0; k < 3; k++) begin
			setup_m = 8'($urandom);
			i_host.access(8'h10, {8'h0, setup_m}, 8, r);
			tick(4);
			cmp_word({8'h0, setup_value}, {8'h0, setup_m});
			i_host.access(8'h18, 16'h0, 8, r);
			cmp_word(r, {8'h0, setup_m});
		end
		i_host.access(8'h28, 16'h0, 8, r);
		cmp_word(r, 16'h0000);
		// Comm read: flag (still high) above the stored low bits
		i_host.access(8'h08, 16'h0, 8, r);
		cmp_word(r, 16'h0088);
		// Lost sequence: half a byte, then a run of ones resynchronises
		i_host.access(8'h10, 16'h0, 0, r);
		i_host.shift(32'h5, 4, r);
		i_host.shift(32'hffffffff, 32, r);
		setup_m = 8'h5a;
		i_host.access(8'h10, {8'h0, setup_m}, 8, r);
		tick(4);
		cmp_word({8'h0, setup_value}, {8'h0, setup_m});
		// Deselect mid-access; clock noise must leave the position alone
		i_host.shift(32'h18, 8, r);
		i_host.sel(1'b0);
		cmp_bit(dout_oe, 1'b0);
		i_host.noise(6);
		i_host.sel(1'b1);
		i_host.shift(32'h0, 8, r);
		cmp_word(r, {8'h0, setup_m});
		// One word straight through
		w = 16'($urandom);
		push(w, ok);
		conv_valid = 1'b0;
		q.push_back(w);
		read_data();
		// Fill until refused while the host stalls
		acc = 0;
		for (int i = 0; i < 12; i++) begin
			w = 16'($urandom);
			push(w, ok);
			if (ok) begin
				q.push_back(w);
				acc++;
			end
		end
		conv_valid = 1'b0;
		cmp_word(16'(acc), 16'(FIFO_DEPTH + 1));
		// First buffered word is replaced unread after the hold
		void'(q.pop_front());
		wait_ready();
		cmp_word(16'(last_high), 16'(HOLD_CYC));
		while (q.size() > 0) read_data();
		cmp_bit(conv_ready, 1'b1);
		cal_done = 1'b1;
		tick(1);
		cal_done = 1'b0;
		tick(1);
		cmp_bit(data_ready_n, 1'b0);
		i_host.sel(1'b0);
		test_done();
	end
endmodule // testbench
